// ==== design/cache_port_pkg.sv ====
package cache_port_pkg;
    // physical address layout
    localparam int PA_W        = 22;  // physical address width
    localparam int BUS_ADDR_W  = 18;  // peripheral bus address width
    localparam int DATA_W      = 16;  // data word width
    localparam int BYTE_SEL_B  = 0;   // byte within word
    localparam int WORD_SEL_B  = 1;   // word within two-word block
    localparam int INDEX_LO    = 2;   // index field low bit
    localparam int INDEX_HI    = 9;   // index field high bit
    localparam int INDEX_W     = 8;   // index field width
    localparam int TAG_LO      = 10;  // tag field low bit
    localparam int TAG_W       = 12;  // tag field width
    localparam int MM_ADDR_LO  = 2;   // main memory block address low bit
    localparam int MM_ADDR_W   = 20;  // main memory block address width
    localparam int REG_SEL_LO  = 1;   // register select low bit
    localparam int REG_SEL_W   = 3;   // register select width
    localparam int NUM_REGS    = 8;   // device registers
    // operation bit encodings
    localparam logic [1:0] OP_WORD_READ      = 2'h0;
    localparam logic [1:0] OP_READ_WITH_PAUSE = 2'h1;
    localparam logic [1:0] OP_WORD_WRITE     = 2'h2;
    localparam logic [1:0] OP_BYTE_WRITE     = 2'h3;
    // main memory model latency in clocks
    localparam int MM_LAT      = 4;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // write decode used by both ends
    function automatic logic op_is_write(input logic [1:0] op);
        return op[1];
    endfunction
endpackage

// ==== design/cache_port_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface cache_port_if;
    // processor side
    logic        bus_start_strobe;  // start of a processor access
    logic        cache_abort;       // processor abandons access
    logic        go_ahead;          // address/op/data valid
    logic [21:0] cpu_addr;          // processor physical address
    logic [1:0]  cpu_op;            // processor operation bits
    logic [15:0] cpu_wdata;         // processor write data
    logic        completion_sync;   // access complete pulse
    logic [15:0] cpu_rdata;         // read data to processor
    // map unit side
    logic        map_request;       // memory or register request
    logic        map_acknowledge;   // request taken
    logic        map_done;          // access complete pulse
    logic        reg_select;        // device register access
    logic [21:0] map_addr;          // translated address
    logic [2:0]  map_reg_addr;      // untranslated bits 03:01
    logic [1:0]  map_op;            // map operation bits
    logic [15:0] map_wdata;         // map write data
    logic [15:0] map_rdata;         // read data to map
    modport cache (
        input  bus_start_strobe, cache_abort, go_ahead, cpu_addr, cpu_op, cpu_wdata,
        output completion_sync, cpu_rdata,
        input  map_request, reg_select, map_addr, map_reg_addr, map_op, map_wdata,
        output map_acknowledge, map_done, map_rdata
    );
    modport requester (
        output bus_start_strobe, cache_abort, go_ahead, cpu_addr, cpu_op, cpu_wdata,
        input  completion_sync, cpu_rdata,
        output map_request, reg_select, map_addr, map_reg_addr, map_op, map_wdata,
        input  map_acknowledge, map_done, map_rdata
    );
endinterface
`default_nettype wire

// ==== design/cache_store.sv ====
`timescale 1ns/1ps
`default_nettype none
// data store, tag memory and a simple main memory array; one-cycle read
module cache_store #(
    parameter int MEM_WORDS = 4096             // backing memory words modelled
) (
    input  wire logic        i_ref_clk,        // clock
    input  wire logic        i_arst_n,         // async reset, active low
    input  wire logic [21:0] i_addr,           // physical address
    input  wire logic        i_fill,           // load block from main memory
    input  wire logic        i_write,          // write through
    input  wire logic        i_byte,           // byte write
    input  wire logic [15:0] i_wdata,          // write data
    output logic             o_hit,            // tag match and valid
    output logic [15:0]      o_fdata,          // fast data store word
    output logic [15:0]      o_mdata           // main memory word
);
    localparam int MW = $clog2(MEM_WORDS);
    logic [15:0] fast_mem [0:511];             // fast data store, two words a block
    logic [11:0] tag_mem  [0:255];             // tag memory
    logic [255:0] valid_reg;                   // block valid bits
    logic [15:0] main_mem [0:MEM_WORDS-1];     // main memory stand-in
    logic [7:0]  idx;                          // index field
    logic [8:0]  fidx;                         // index plus word select
    logic [MW-1:0] midx;                       // main memory word index
    logic [15:0] merged;                       // byte-merged write word

    assign idx  = i_addr[cache_port_pkg::INDEX_HI:cache_port_pkg::INDEX_LO];
    assign fidx = {idx, i_addr[cache_port_pkg::WORD_SEL_B]};
    assign midx = i_addr[MW:1];
    assign o_hit = valid_reg[idx] &&
        tag_mem[idx] == i_addr[cache_port_pkg::PA_W-1:cache_port_pkg::TAG_LO];
    assign o_fdata = fast_mem[fidx];
    assign o_mdata = main_mem[midx];

    // byte lane pick by bit 00
    always_comb begin
        merged = i_wdata;
        if (i_byte) begin
            if (i_addr[cache_port_pkg::BYTE_SEL_B]) begin
                merged = {i_wdata[7:0], main_mem[midx][7:0]};
            end else begin
                merged = {main_mem[midx][15:8], i_wdata[7:0]};
            end
        end
    end

    // valid bits need reset; arrays do not
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            valid_reg <= '0;
        end else if (i_fill) begin
            valid_reg[idx] <= 1'b1;
        end
    end

    // fill both words of the block, or update on write hit
    always_ff @(posedge i_ref_clk) begin
        if (i_fill) begin
            tag_mem[idx] <= i_addr[cache_port_pkg::PA_W-1:cache_port_pkg::TAG_LO];
            fast_mem[{idx, 1'b0}] <= main_mem[{midx[MW-1:1], 1'b0}];
            fast_mem[{idx, 1'b1}] <= main_mem[{midx[MW-1:1], 1'b1}];
        end else if (i_write && o_hit) begin
            fast_mem[fidx] <= merged;
        end
        if (i_write) begin
            main_mem[midx] <= merged;
        end
    end
endmodule
`default_nettype wire

// ==== design/cache_port.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - processor drives strobe, address, op, data
// - strobe starts cache timing
// - abort returns cache to idle
// - cache waits for go-ahead
// - read hit returns store word, sync
// - read miss fetches memory then sync
// - write completes in memory, then sync
// - processor stalls until completion sync
// - bus device drives address then master sync
// - map translates 18-bit to 22-bit
// - master sync raises map request
// - cache acknowledges; map drops request
// - map read hit: word, map done
// - map read miss: fetch, then done
// - map write: memory first, then done
// - map done leads to slave sync
// - register address asserts register select
// - register chosen by bits 03:01
// - register read/write then map done
// - bits 00,01,09:02 address the store
// - miss sends bits 21:02 to memory
// - op bits: read, pause read, write, byte
module cache_port #(
    parameter int MEM_WORDS = 4096                   // modelled main memory size
) (
    input  wire logic  i_ref_clk,                    // clock
    input  wire logic  i_arst_n,                     // async reset, active low
    cache_port_if.cache bus,                         // both requesters
    output logic [19:0] o_mm_addr,                   // main memory block address
    output logic        o_mm_cycle                   // main memory cycle in progress
);
    // state IDLE: wait for strobe or request
    // state WAIT_GO: cpu holds the cache
    // state LOOKUP: one-cycle tag compare
    // state MEMCYC: MM_LAT memory cycles
    // state FINISH: data set, pulse next
    typedef enum logic [2:0] {IDLE, WAIT_GO, LOOKUP, MEMCYC, FINISH} state_e;
    state_e      state_reg;                          // access sequencer
    logic        from_map_reg;                       // current access owner is map
    logic        is_reg_reg;                         // current access is a register
    logic [21:0] addr_reg;                           // captured address
    logic [1:0]  op_reg;                             // captured operation
    logic [15:0] wdata_reg;                          // captured write data
    logic [2:0]  cnt_reg;                            // memory latency count
    logic [15:0] dev_regs [0:cache_port_pkg::NUM_REGS-1]; // cache device registers
    logic        hit;                                // store lookup
    logic [15:0] fdata;                              // fast store word
    logic [15:0] mdata;                              // main memory word
    logic        fill;                               // fill block this cycle
    logic        wr;                                 // write through this cycle
    logic        done_now;                           // memory cycle finishing

    // misses fill and writes land on the last count
    assign done_now = state_reg == MEMCYC &&
        cnt_reg == 3'(cache_port_pkg::MM_LAT - 1);
    assign fill = done_now && !cache_port_pkg::op_is_write(op_reg);
    assign wr   = done_now && cache_port_pkg::op_is_write(op_reg);

    // store sees captured values only, so inputs
    // may move once an access has been taken
    cache_store #(.MEM_WORDS(MEM_WORDS)) u_store (
        .i_ref_clk (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .i_addr    (addr_reg),
        .i_fill    (fill),
        .i_write   (wr),
        .i_byte    (op_reg == cache_port_pkg::OP_BYTE_WRITE),
        .i_wdata   (wdata_reg),
        .o_hit     (hit),
        .o_fdata   (fdata),
        .o_mdata   (mdata)
    );

    // sequencer; processor strobe has priority over map request
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg    <= IDLE;
            from_map_reg <= 1'b0;
            is_reg_reg   <= 1'b0;
            addr_reg     <= '0;
            op_reg       <= '0;
            wdata_reg    <= '0;
            cnt_reg      <= '0;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    // map has no deadline, so cpu wins a tie
                    if (bus.bus_start_strobe) begin
                        state_reg    <= WAIT_GO;
                        from_map_reg <= 1'b0;
                        is_reg_reg   <= 1'b0;
                    end else if (bus.map_request) begin
                        state_reg    <= LOOKUP;
                        from_map_reg <= 1'b1;
                        is_reg_reg   <= bus.reg_select;
                        addr_reg     <= bus.map_addr;
                        op_reg       <= bus.map_op;
                        wdata_reg    <= bus.map_wdata;
                    end
                end
                WAIT_GO: begin
                    // abort wins if both arrive together
                    if (bus.cache_abort) begin
                        state_reg <= IDLE;
                    end else if (bus.go_ahead) begin
                        state_reg <= LOOKUP;
                        addr_reg  <= bus.cpu_addr;
                        op_reg    <= bus.cpu_op;
                        wdata_reg <= bus.cpu_wdata;
                    end
                end
                LOOKUP: begin
                    cnt_reg <= '0;
                    if (is_reg_reg || (hit && !cache_port_pkg::op_is_write(op_reg))) begin
                        state_reg <= FINISH;
                    end else begin
                        state_reg <= MEMCYC;
                    end
                end
                MEMCYC: begin
                    // count runs from 0 to MM_LAT-1
                    cnt_reg <= cnt_reg + 3'h1;
                    if (done_now) begin
                        state_reg <= FINISH;
                    end
                end
                FINISH: begin
                    // spare cycle so data settles before pulse
                    state_reg <= IDLE;
                end
            endcase
        end
    end

    // device registers: only bits 03:01 pick one
    // limitation: register writes skip the store
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < cache_port_pkg::NUM_REGS; i++) begin
                dev_regs[i] <= cache_port_pkg::REG_RESET;
            end
        end else if (state_reg == LOOKUP && is_reg_reg &&
                     cache_port_pkg::op_is_write(op_reg)) begin
            dev_regs[bus.map_reg_addr] <= wdata_reg;
        end
    end

    // acknowledge a map request for one cycle as it is taken
    // request is still high during the pulse cycle and
    // drops after it; the sequencer has left IDLE by then
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus.map_acknowledge <= 1'b0;
        end else begin
            bus.map_acknowledge <= state_reg == IDLE && !bus.bus_start_strobe &&
                                   bus.map_request;
        end
    end

    // read data: from memory on the fill cycle, else store or register
    // on a hit the LOOKUP value stands to the pulse
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus.cpu_rdata <= '0;
            bus.map_rdata <= '0;
        end else if (state_reg == LOOKUP || fill) begin
            if (from_map_reg) begin
                bus.map_rdata <= is_reg_reg ? dev_regs[bus.map_reg_addr] :
                                 (fill ? mdata : fdata);
            end else begin
                bus.cpu_rdata <= fill ? mdata : fdata;
            end
        end
    end

    // completion pulses follow the data by one cycle at least
    // pulses stand one cycle; nobody may count on more
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus.completion_sync <= 1'b0;
            bus.map_done        <= 1'b0;
        end else begin
            bus.completion_sync <= state_reg == FINISH && !from_map_reg;
            bus.map_done        <= state_reg == FINISH && from_map_reg;
        end
    end

    // main memory address bits 21:02 during a miss or write
    // latched on hits too; o_mm_cycle marks real cycles
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mm_addr  <= '0;
            o_mm_cycle <= 1'b0;
        end else begin
            o_mm_cycle <= state_reg == MEMCYC && !done_now;
            if (state_reg == LOOKUP) begin
                o_mm_addr <= addr_reg[cache_port_pkg::PA_W-1:cache_port_pkg::MM_ADDR_LO];
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/cache_requester.sv ====
`timescale 1ns/1ps
`default_nettype none
// processor and map unit ends facing the cache
module cache_requester (
    input  wire logic        i_ref_clk,        // clock
    input  wire logic        i_arst_n,         // async reset, active low
    cache_port_if.requester  bus,              // cache link
    input  wire logic        i_cpu_start,      // processor access request pulse
    input  wire logic        i_cpu_abandon,    // abort instead of go-ahead
    input  wire logic [21:0] i_cpu_addr,       // processor address
    input  wire logic [1:0]  i_cpu_op,         // processor op bits
    input  wire logic [15:0] i_cpu_wdata,      // processor write data
    output logic             o_cpu_stall,      // processor paused
    output logic [15:0]      o_buffer_register,// processor read buffer
    input  wire logic        i_master_sync,    // peripheral bus master sync
    input  wire logic [17:0] i_bus_addr,       // 18-bit bus address
    input  wire logic [1:0]  i_bus_op,         // bus op bits
    input  wire logic [15:0] i_bus_wdata,      // bus write data
    input  wire logic        i_bus_is_reg,     // address hits cache device register
    input  wire logic [5:0]  i_relocate,       // relocation high bits
    output logic             o_slave_sync,     // peripheral bus slave sync
    output logic [15:0]      o_bus_rdata       // data latched for bus
);
    typedef enum logic [1:0] {C_IDLE, C_GO, C_WAIT} cpu_e;
    typedef enum logic [1:0] {M_IDLE, M_REQ, M_WAIT, M_END} map_e;
    cpu_e cpu_reg;                             // processor access state
    map_e map_reg;                             // map unit state

    // processor: strobe, then go-ahead or abort, then pause until sync
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cpu_reg              <= C_IDLE;
            bus.bus_start_strobe <= 1'b0;
            bus.go_ahead         <= 1'b0;
            bus.cache_abort      <= 1'b0;
            bus.cpu_addr         <= '0;
            bus.cpu_op           <= '0;
            bus.cpu_wdata        <= '0;
            o_cpu_stall          <= 1'b0;
            o_buffer_register    <= '0;
        end else begin
            bus.bus_start_strobe <= 1'b0;
            bus.go_ahead         <= 1'b0;
            bus.cache_abort      <= 1'b0;
            unique case (cpu_reg)
                C_IDLE: if (i_cpu_start) begin
                    bus.bus_start_strobe <= 1'b1;
                    bus.cpu_addr  <= i_cpu_addr;
                    bus.cpu_op    <= i_cpu_op;
                    bus.cpu_wdata <= i_cpu_wdata;
                    o_cpu_stall   <= ~i_cpu_abandon;
                    cpu_reg       <= C_GO;
                end
                C_GO: begin
                    bus.go_ahead    <= o_cpu_stall;
                    bus.cache_abort <= ~o_cpu_stall;
                    cpu_reg         <= o_cpu_stall ? C_WAIT : C_IDLE;
                end
                C_WAIT: if (bus.completion_sync) begin
                    o_cpu_stall <= 1'b0;
                    cpu_reg     <= C_IDLE;
                    if (!cache_port_pkg::op_is_write(bus.cpu_op)) begin
                        o_buffer_register <= bus.cpu_rdata;
                    end
                end
            endcase
        end
    end

    // map unit: translate, request, drop on acknowledge, latch on done
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            map_reg          <= M_IDLE;
            bus.map_request  <= 1'b0;
            bus.reg_select   <= 1'b0;
            bus.map_addr     <= '0;
            bus.map_reg_addr <= '0;
            bus.map_op       <= '0;
            bus.map_wdata    <= '0;
            o_slave_sync     <= 1'b0;
            o_bus_rdata      <= '0;
        end else begin
            unique case (map_reg)
                M_IDLE: if (i_master_sync) begin
                    bus.map_request  <= 1'b1;
                    bus.reg_select   <= i_bus_is_reg;
                    bus.map_addr     <= {4'h0, i_bus_addr} + {i_relocate, 16'h0000};
                    bus.map_reg_addr <= i_bus_addr[3:1];
                    bus.map_op       <= i_bus_op;
                    bus.map_wdata    <= i_bus_wdata;
                    map_reg          <= M_REQ;
                end
                M_REQ: if (bus.map_acknowledge) begin
                    bus.map_request <= 1'b0;
                    map_reg         <= M_WAIT;
                end
                M_WAIT: if (bus.map_done) begin
                    o_bus_rdata  <= bus.map_rdata;
                    o_slave_sync <= 1'b1;
                    map_reg      <= M_END;
                end
                M_END: if (!i_master_sync) begin
                    o_slave_sync <= 1'b0;
                    map_reg      <= M_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== dv/cache_port_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches the link between both ends; figures assume a memory latency of 4
module cache_port_props (
    input wire logic       i_ref_clk,        // clock
    input wire logic       i_arst_n,         // async reset, active low
    input wire logic       bus_start_strobe, // cpu start
    input wire logic       cache_abort,      // cpu abort
    input wire logic       go_ahead,         // cpu go
    input wire logic [1:0] cpu_op,           // cpu op bits
    input wire logic       completion_sync,  // cpu done pulse
    input wire logic       map_request,      // map request
    input wire logic       map_acknowledge,  // map ack pulse
    input wire logic       map_done,         // map done pulse
    input wire logic       reg_select,       // register access
    input wire logic [1:0] map_op            // map op bits
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // writes other than register writes always wait out the whole memory cycle, so the gap is exact
    sequence s_cpu_mem; !completion_sync [*6] ##1 completion_sync; endsequence
    sequence s_map_mem; !map_done [*5] ##1 map_done; endsequence
    property p_go_next; bus_start_strobe |=> go_ahead || cache_abort; endproperty
    property p_cpu_rd; go_ahead && !cpu_op[1] |-> ##[3:7] completion_sync; endproperty
    property p_cpu_wr; go_ahead && cpu_op[1] |=> s_cpu_mem; endproperty
    property p_abort; cache_abort |=> !completion_sync [*5]; endproperty
    property p_req_ack; map_request && !map_acknowledge |-> ##[1:12] map_acknowledge; endproperty
    property p_ack_drop; map_acknowledge |=> !map_request; endproperty
    property p_map_rd; map_acknowledge && !map_op[1] && !reg_select |-> ##[2:7] map_done; endproperty
    property p_map_wr; map_acknowledge && map_op[1] && !reg_select |=> s_map_mem; endproperty
    property p_reg; map_acknowledge && reg_select |-> ##2 map_done; endproperty
    a_go_next: assert property (p_go_next) else $error("no go after start");
    a_cpu_rd: assert property (p_cpu_rd) else $error("cpu read sync late");
    a_cpu_wr: assert property (p_cpu_wr) else $error("cpu write sync early");
    a_abort: assert property (p_abort) else $error("sync after abort");
    a_req_ack: assert property (p_req_ack) else $error("request not acked");
    a_ack_drop: assert property (p_ack_drop) else $error("request held");
    a_map_rd: assert property (p_map_rd) else $error("map read done late");
    a_map_wr: assert property (p_map_wr) else $error("map write done early");
    a_reg: assert property (p_reg) else $error("register done late");
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
    logic        ref_clk = 1'b0;  // 25 MHz
    logic        arst_n = 1'b0;   // reset
    logic        start = 1'b0;    // cpu start
    logic        abandon = 1'b0;  // cpu abort
    logic [21:0] addr = '0;       // cpu address
    logic [1:0]  op = '0;         // cpu op
    logic [15:0] wdata = '0;      // cpu data
    logic        stall;           // cpu paused
    logic [15:0] buf_reg;         // cpu buffer
    logic        msync = 1'b0;    // master sync
    logic [17:0] baddr = '0;      // bus address
    logic [1:0]  bop = '0;        // bus op
    logic [15:0] bwdata = '0;     // bus data
    logic        is_reg = 1'b0;   // register hit
    logic        ssync;           // slave sync
    logic [15:0] brdata;          // bus read data
    logic [19:0] mm_addr;         // memory address
    logic        mm_cycle;        // memory cycle busy
    int          n_mismatch = 0;  // mismatches
    int          checks = 0;      // comparisons
    cache_port_if bus_if ();
    cache_port cache_port_inst (.i_ref_clk(ref_clk), .i_arst_n(arst_n), .bus(bus_if),
        .o_mm_addr(mm_addr), .o_mm_cycle(mm_cycle));
    cache_requester cache_requester_inst (.i_ref_clk(ref_clk), .i_arst_n(arst_n),
        .bus(bus_if), .i_cpu_start(start), .i_cpu_abandon(abandon), .i_cpu_addr(addr),
        .i_cpu_op(op), .i_cpu_wdata(wdata), .o_cpu_stall(stall), .o_buffer_register(buf_reg),
        .i_master_sync(msync), .i_bus_addr(baddr), .i_bus_op(bop), .i_bus_wdata(bwdata),
        .i_bus_is_reg(is_reg), .i_relocate(6'h01), .o_slave_sync(ssync),
        .o_bus_rdata(brdata));
    cache_port_props cache_port_props_inst (.i_ref_clk(ref_clk), .i_arst_n(arst_n),
        .bus_start_strobe(bus_if.bus_start_strobe), .cache_abort(bus_if.cache_abort),
        .go_ahead(bus_if.go_ahead), .cpu_op(bus_if.cpu_op),
        .completion_sync(bus_if.completion_sync), .map_request(bus_if.map_request),
        .map_acknowledge(bus_if.map_acknowledge), .map_done(bus_if.map_done),
        .reg_select(bus_if.reg_select), .map_op(bus_if.map_op));
    // clock
    always #20 ref_clk = ~ref_clk;
    // verdict, reached from the main sequence or the watchdog
    task automatic stop_test;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one cpu access; waits for the sync pulse, bounded
    task automatic cpu(input logic [21:0] a, input logic [1:0] o, input logic [15:0] d,
                       input logic [15:0] e);
        int n, busy;
        @(negedge ref_clk);
        start = 1'b1;
        addr = a;
        op = o;
        wdata = d;
        @(negedge ref_clk);
        start = 1'b0;
        busy = 0;
        for (n = 0; n < 40 && bus_if.completion_sync !== 1'b1; n++) begin
            busy += int'(mm_cycle);
            @(negedge ref_clk);
        end
        `CHK("sync", 1'b1, bus_if.completion_sync)
        @(negedge ref_clk);
        `CHK("stall", 1'b0, stall)
        if (!o[1]) `CHK("buffer", e, buf_reg)
        `CHK("mm addr", a[21:2], mm_addr)
        if (o[1]) `CHK("mm cycle", cache_port_pkg::MM_LAT - 1, busy)
    endtask
    // start then abort: nothing must complete or load
    task automatic cpu_abort;
        @(negedge ref_clk);
        start = 1'b1;
        abandon = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        abandon = 1'b0;
        repeat (6) @(negedge ref_clk);
        `CHK("abort stall", 1'b0, stall)
        `CHK("abort buffer", 16'hAB34, buf_reg)
    endtask
    // one bus transfer through the map unit; sync raised after a deskew cycle
    task automatic map(input logic [17:0] a, input logic [1:0] o, input logic [15:0] d,
                       input logic r, input logic [15:0] e);
        int n;
        @(negedge ref_clk);
        baddr = a;
        bop = o;
        bwdata = d;
        is_reg = r;
        @(negedge ref_clk);
        msync = 1'b1;
        for (n = 0; n < 40 && ssync !== 1'b1; n++) @(negedge ref_clk);
        `CHK("slave sync", 1'b1, ssync)
        if (!o[1]) `CHK("bus data", e, brdata)
        msync = 1'b0;
        for (n = 0; n < 40 && ssync !== 1'b0; n++) @(negedge ref_clk);
    endtask
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge ref_clk);
        arst_n = 1'b1;
        cpu(22'h000104, cache_port_pkg::OP_WORD_WRITE, 16'h1234, 16'h0000);
        cpu(22'h000104, cache_port_pkg::OP_WORD_READ, 16'h0000, 16'h1234);
        cpu(22'h000104, cache_port_pkg::OP_READ_WITH_PAUSE, 16'h0000, 16'h1234);
        cpu(22'h000105, cache_port_pkg::OP_BYTE_WRITE, 16'hABAB, 16'h0000);
        cpu(22'h000104, cache_port_pkg::OP_WORD_READ, 16'h0000, 16'hAB34);
        cpu_abort();
        map(18'h00208, cache_port_pkg::OP_WORD_WRITE, 16'h5A5A, 1'b0, 16'h0000);
        map(18'h00208, cache_port_pkg::OP_WORD_READ, 16'h0000, 1'b0, 16'h5A5A);
        map(18'h00208, cache_port_pkg::OP_WORD_READ, 16'h0000, 1'b0, 16'h5A5A);
        map(18'h0000A, cache_port_pkg::OP_WORD_WRITE, 16'hC3C3, 1'b1, 16'h0000);
        map(18'h3FFFA, cache_port_pkg::OP_WORD_READ, 16'h0000, 1'b1, 16'hC3C3);
        map(18'h00008, cache_port_pkg::OP_WORD_READ, 16'h0000, 1'b1, 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
